// ### verilog/gp_timer_consts.vh
// Operation
// - 32-bit counter counts up by one per prescaled tick while started.
// - overflow, compare match and capture each raise own interrupt cause.
// - functional clock divided by 2 to the n, n from 0 to 8.
// - 32-bit data path; full-word and 16-bit half-word accesses accepted.
// - 10-bit register address, single transfers only, no bursts.
// - writes are done on the same edge that raises the acknowledge.
// - compare flags count equal compare; capture latches count on event.
// - capture input pin; trigger or PWM output from overflow, compare.
// - general-purpose output set by a software bit, apart from counting.
// - all registers, counter included, read while counting; all but capture also written.
// - tick instance makes accurate 1 ms interrupt from 32.768 kHz clock.
// - functional clock chosen outside; block sees it as an enable pulse.
// - one external pin, used as PWM output or as capture input.
`ifndef GP_TIMER_CONSTS_VH
`define GP_TIMER_CONSTS_VH

// word indices; byte address is four times the index
`define GPT_IDX_CTRL     8'h00
`define GPT_IDX_COUNT    8'h01
`define GPT_IDX_RELOAD   8'h02
`define GPT_IDX_COMPARE  8'h03
`define GPT_IDX_CAPTURE  8'h04
`define GPT_IDX_IRQ_STAT 8'h05
`define GPT_IDX_IRQ_MASK 8'h06
`define GPT_IDX_TICK     8'h07

// control register fields
`define GPT_CTRL_W         12
`define GPT_CTRL_START     0
`define GPT_CTRL_AUTOLOAD  1
`define GPT_CTRL_CMP_EN    2
`define GPT_CTRL_CAP_EN    3
`define GPT_CTRL_PRE_LSB   4
`define GPT_CTRL_PRE_MSB   7
`define GPT_CTRL_CAP_FALL  8
`define GPT_CTRL_PWM_TGL   9
`define GPT_CTRL_PIN_OUT   10
`define GPT_CTRL_GPO       11

// interrupt causes
`define GPT_IRQ_W    4
`define GPT_IRQ_OVF  0
`define GPT_IRQ_CMP  1
`define GPT_IRQ_CAP  2
`define GPT_IRQ_TICK 3

// reset values
`define GPT_CTRL_RST    12'h000
`define GPT_COUNT_RST   32'h00000000
`define GPT_RELOAD_RST  32'h00000000
`define GPT_COMPARE_RST 32'hffffffff
`define GPT_MASK_RST    4'h0
`define GPT_CAPTURE_RST 32'h00000000
`define GPT_STAT_RST    4'h0

// prescaler and tick timing
`define GPT_PRE_MAX    4'h8
`define GPT_TICK_STEP  16'h03e8
`define GPT_TICK_MOD   16'h8000

`endif

// ### verilog/timer_prescaler.v
`timescale 1ns/1ps
`default_nettype none
`include "gp_timer_consts.vh"

module timer_prescaler (
  input  wire       clk_i,
  input  wire       reset_i,
  input  wire       run_i,
  input  wire       fclk_en_i,
  input  wire [3:0] div_exp_i,
  output wire       tick_o
);

  reg  [7:0] cnt_ff;
  wire [7:0] mask;

  function [7:0] low_mask;
    input [3:0] n;
    begin
      if (n >= `GPT_PRE_MAX) begin
        low_mask = 8'hff;
      end else begin
        low_mask = (8'h01 << n) - 8'h01;
      end
    end
  endfunction

  assign mask = low_mask(div_exp_i);

  assign tick_o = run_i & fclk_en_i & ((cnt_ff & mask) == mask);

  always @(posedge clk_i) begin
    if (reset_i) begin
      cnt_ff <= 8'h00;
    end else if (!run_i) begin
      cnt_ff <= 8'h00;
    end else if (fclk_en_i) begin
      cnt_ff <= cnt_ff + 8'h01;
    end
  end

endmodule // timer_prescaler
`default_nettype wire

// ### verilog/general_purpose_timer.v
`timescale 1ns/1ps
`default_nettype none
`include "gp_timer_consts.vh"

module general_purpose_timer #(
  parameter TICK_INSTANCE = 1
) (
  input  wire        clk_i,
  input  wire        reset_i,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [9:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output wire [31:0] wb_dat_o,
  output wire        wb_ack_o,
  input  wire        fclk_en_i,
  input  wire        pin_i,
  output wire        pin_o,
  output wire        pin_oe_o,
  output wire        trig_o,
  output wire        gpo_o,
  output wire        irq_o
);

  reg  [`GPT_CTRL_W-1:0] ctrl_ff;
  reg  [`GPT_CTRL_W-1:0] nxt_ctrl;
  reg  [31:0]            cnt_ff;
  reg  [31:0]            nxt_cnt;
  reg  [31:0]            cnt_count;
  reg  [31:0]            reload_ff;
  reg  [31:0]            compare_ff;
  reg  [31:0]            capture_ff;
  reg  [`GPT_IRQ_W-1:0]  stat_ff;
  reg  [`GPT_IRQ_W-1:0]  nxt_stat;
  reg  [`GPT_IRQ_W-1:0]  mask_ff;
  reg                    tick_en_ff;
  reg  [15:0]            tick_acc_ff;
  reg  [15:0]            nxt_tick_acc;
  reg                    tick_evt;
  reg                    pin_prev_ff;
  reg                    trig_ff;
  reg                    ack_ff;
  reg  [31:0]            dat_ff;
  reg  [31:0]            rd_data;
  reg                    ovf_evt;

  wire                   req;
  wire                   wr;
  wire [7:0]             word_idx;
  wire                   wr_ctrl;
  wire                   wr_cnt;
  wire                   wr_reload;
  wire                   wr_compare;
  wire                   wr_stat;
  wire                   wr_mask;
  wire                   wr_tick;
  wire [3:0]             pre_raw;
  wire [3:0]             pre_exp;
  wire                   running;
  wire                   cnt_tick;
  wire                   cmp_evt;
  wire                   cap_edge;
  wire                   cap_evt;
  wire [`GPT_IRQ_W-1:0]  events;
  wire [`GPT_IRQ_W-1:0]  stat_clr;
  wire [31:0]            ctrl_wr_word;

  // byte-lane merge for full-word and half-word writes
  function [31:0] merge;
    input [31:0] old_val;
    input [31:0] new_val;
    input [3:0]  sel;
    integer      i;
    begin
      merge = old_val;
      for (i = 0; i < 4; i = i + 1) begin
        if (sel[i]) begin
          merge[i*8 +: 8] = new_val[i*8 +: 8];
        end
      end
    end
  endfunction

  // only full words and aligned halves write
  function sel_ok;
    input [3:0] sel;
    begin
      sel_ok = (sel == 4'hf) || (sel == 4'h3) || (sel == 4'hc);
    end
  endfunction

  // bus slave
  // single transfers
  assign req      = wb_cyc_i & wb_stb_i & ~ack_ff;
  assign wr       = req & wb_we_i & sel_ok(wb_sel_i);
  assign word_idx = wb_adr_i[9:2];

  assign wr_ctrl    = wr & (word_idx == `GPT_IDX_CTRL);
  assign wr_cnt     = wr & (word_idx == `GPT_IDX_COUNT);
  assign wr_reload  = wr & (word_idx == `GPT_IDX_RELOAD);
  assign wr_compare = wr & (word_idx == `GPT_IDX_COMPARE);
  assign wr_stat    = wr & (word_idx == `GPT_IDX_IRQ_STAT);
  assign wr_mask    = wr & (word_idx == `GPT_IDX_IRQ_MASK);
  assign wr_tick    = wr & (word_idx == `GPT_IDX_TICK);

  always @* begin
    rd_data = 32'h00000000;
    case (word_idx)
      `GPT_IDX_CTRL:     rd_data[`GPT_CTRL_W-1:0] = ctrl_ff;
      `GPT_IDX_COUNT:    rd_data = cnt_ff;
      `GPT_IDX_RELOAD:   rd_data = reload_ff;
      `GPT_IDX_COMPARE:  rd_data = compare_ff;
      `GPT_IDX_CAPTURE:  rd_data = capture_ff;
      `GPT_IDX_IRQ_STAT: rd_data[`GPT_IRQ_W-1:0] = stat_ff;
      `GPT_IDX_IRQ_MASK: rd_data[`GPT_IRQ_W-1:0] = mask_ff;
      `GPT_IDX_TICK:     rd_data[0] = tick_en_ff;
      default:           rd_data = 32'h00000000;
    endcase
  end

  // ack blocks req for a cycle, so a held request is taken again every second cycle
  // write lands with ack
  always @(posedge clk_i) begin
    if (reset_i) begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h00000000;
    end else begin
      ack_ff <= req;
      if (req && !wb_we_i) begin
        dat_ff <= rd_data;
      end
    end
  end

  assign wb_dat_o = dat_ff;
  assign wb_ack_o = ack_ff;

  // prescaler
  assign pre_raw = ctrl_ff[`GPT_CTRL_PRE_MSB:`GPT_CTRL_PRE_LSB];
  // field codes above eight act as eight
  assign pre_exp = (pre_raw > `GPT_PRE_MAX) ? `GPT_PRE_MAX : pre_raw;
  assign running = ctrl_ff[`GPT_CTRL_START];

  timer_prescaler u_prescaler (
    .clk_i     (clk_i),
    .reset_i   (reset_i),
    .run_i     (running),
    .fclk_en_i (fclk_en_i),
    .div_exp_i (pre_exp),
    .tick_o    (cnt_tick)
  );

  // counter
  always @* begin
    cnt_count = cnt_ff;
    ovf_evt   = 1'b0;
    if (cnt_tick) begin
      if (cnt_ff == 32'hffffffff) begin
        ovf_evt = 1'b1;
        if (ctrl_ff[`GPT_CTRL_AUTOLOAD]) begin
          cnt_count = reload_ff;
        end else begin
          cnt_count = 32'h00000000;
        end
      end else begin
        cnt_count = cnt_ff + 32'h00000001;
      end
    end
    nxt_cnt = cnt_count;
    // a count write beats the tick of the same cycle
    // write while counting
    if (wr_cnt) begin
      nxt_cnt = merge(cnt_ff, wb_dat_i, wb_sel_i);
    end
  end

  // ctrl keeps only its own bits of the bus word
  assign ctrl_wr_word = merge({20'h00000, ctrl_ff}, wb_dat_i, wb_sel_i);

  always @* begin
    nxt_ctrl = ctrl_ff;
    if (ovf_evt && !ctrl_ff[`GPT_CTRL_AUTOLOAD]) begin
      nxt_ctrl[`GPT_CTRL_START] = 1'b0;
    end
    if (wr_ctrl) begin
      nxt_ctrl = ctrl_wr_word[`GPT_CTRL_W-1:0];
    end
  end

  // compare and capture
  // compare match
  assign cmp_evt  = ctrl_ff[`GPT_CTRL_CMP_EN] & cnt_tick &
                    (cnt_count == compare_ff);
  // edge detector runs even while capture is off
  assign cap_edge = ctrl_ff[`GPT_CTRL_CAP_FALL] ? (pin_prev_ff & ~pin_i)
                                                : (~pin_prev_ff & pin_i);
  assign cap_evt  = ctrl_ff[`GPT_CTRL_CAP_EN] &
                    ~ctrl_ff[`GPT_CTRL_PIN_OUT] & cap_edge;

  // 1 ms tick
  // acc stays below mod plus step, so 16 bits never wrap
  // fractional 1000/32768
  always @* begin
    nxt_tick_acc = tick_acc_ff;
    tick_evt     = 1'b0;
    if (TICK_INSTANCE != 0 && tick_en_ff && fclk_en_i) begin
      nxt_tick_acc = tick_acc_ff + `GPT_TICK_STEP;
      if (nxt_tick_acc >= `GPT_TICK_MOD) begin
        nxt_tick_acc = nxt_tick_acc - `GPT_TICK_MOD;
        tick_evt     = 1'b1;
      end
    end
  end

  // interrupt status
  // distinct causes
  assign events   = {tick_evt, cap_evt, cmp_evt, ovf_evt};
  // status, mask and tick enable use byte lane 0 only
  assign stat_clr = (wr_stat && wb_sel_i[0]) ? wb_dat_i[`GPT_IRQ_W-1:0]
                                              : {`GPT_IRQ_W{1'b0}};

  always @* begin
    // set beats clear
    nxt_stat = (stat_ff & ~stat_clr) | events;
  end

  // level output, held until status is cleared or masked
  assign irq_o = |(stat_ff & mask_ff);

  // registers
  always @(posedge clk_i) begin
    if (reset_i) begin
      ctrl_ff     <= `GPT_CTRL_RST;
      cnt_ff      <= `GPT_COUNT_RST;
      reload_ff   <= `GPT_RELOAD_RST;
      compare_ff  <= `GPT_COMPARE_RST;
      capture_ff  <= `GPT_CAPTURE_RST;
      stat_ff     <= `GPT_STAT_RST;
      mask_ff     <= `GPT_MASK_RST;
      tick_en_ff  <= 1'b0;
      tick_acc_ff <= 16'h0000;
      pin_prev_ff <= 1'b0;
    end else begin
      ctrl_ff     <= nxt_ctrl;
      cnt_ff      <= nxt_cnt;
      stat_ff     <= nxt_stat;
      tick_acc_ff <= nxt_tick_acc;
      pin_prev_ff <= pin_i;
      if (wr_reload) begin
        reload_ff <= merge(reload_ff, wb_dat_i, wb_sel_i);
      end
      if (wr_compare) begin
        compare_ff <= merge(compare_ff, wb_dat_i, wb_sel_i);
      end
      // the count as it stood before this edge
      // capture latches count
      if (cap_evt) begin
        capture_ff <= cnt_ff;
      end
      if (wr_mask && wb_sel_i[0]) begin
        mask_ff <= wb_dat_i[`GPT_IRQ_W-1:0];
      end
      if (wr_tick && wb_sel_i[0]) begin
        tick_en_ff <= wb_dat_i[0];
      end
    end
  end

  // trigger and PWM output
  // toggle mode gives PWM, else a one-cycle trigger pulse
  // trigger from overflow and compare
  always @(posedge clk_i) begin
    if (reset_i) begin
      trig_ff <= 1'b0;
    end else if (ctrl_ff[`GPT_CTRL_PWM_TGL]) begin
      trig_ff <= trig_ff ^ (ovf_evt | cmp_evt);
    end else begin
      trig_ff <= ovf_evt | cmp_evt;
    end
  end

  assign trig_o   = trig_ff;
  assign pin_o    = trig_ff;
  // pin drives only while the output bit is set
  assign pin_oe_o = ctrl_ff[`GPT_CTRL_PIN_OUT];
  assign gpo_o    = ctrl_ff[`GPT_CTRL_GPO];

endmodule // general_purpose_timer
`default_nettype wire

// ### verification/gp_timer_properties.sv
`timescale 1ns/1ps
`default_nettype none
module gp_timer_properties (
  input wire logic        clk_i,
  input wire logic        reset_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [9:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        pin_o,
  input wire logic        pin_oe_o,
  input wire logic        trig_o,
  input wire logic        gpo_o,
  input wire logic        irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  sequence req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence ctrl_wr_s;
    req_s ##0 wb_we_i && wb_adr_i[9:2] == 8'h00 && wb_sel_i == 4'hf;
  endsequence
  sequence mask_off_s;
    req_s ##0 wb_we_i && wb_adr_i[9:2] == 8'h06 && wb_sel_i == 4'hf
      && wb_dat_i[3:0] == 4'h0;
  endsequence
  sequence rd_far_s;
    req_s ##0 !wb_we_i && wb_adr_i[9:5] != 5'h00;
  endsequence
  ack_follows_a: assert property (req_s |=> wb_ack_o)
    else $error("no ack one cycle after request");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property (
    wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  gpo_follow_a: assert property (
    ctrl_wr_s |=> gpo_o == $past(wb_dat_i[11]))
    else $error("gpo level wrong after control write");
  oe_follow_a: assert property (
    ctrl_wr_s |=> pin_oe_o == $past(wb_dat_i[10]))
    else $error("pin direction wrong after control write");
  pin_trig_a: assert property (pin_o == trig_o)
    else $error("pin drive differs from trigger");
  irq_masked_a: assert property (mask_off_s |=> !irq_o)
    else $error("irq high with all causes masked");
  unmapped_rd_a: assert property (rd_far_s |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
endmodule // gp_timer_properties
bind general_purpose_timer gp_timer_properties u_props (
  .clk_i(clk_i), .reset_i(reset_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .pin_o(pin_o), .pin_oe_o(pin_oe_o),
  .trig_o(trig_o), .gpo_o(gpo_o), .irq_o(irq_o));
`default_nettype wire

// ### verification/wb_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module wb_master_model (
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  input  wire logic [31:0] dat_i,
  output var  logic        cyc_o,
  output var  logic        stb_o,
  output var  logic        we_o,
  output var  logic [9:0]  adr_o,
  output var  logic [3:0]  sel_o,
  output var  logic [31:0] dat_o
);
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o = 1'b0;
    adr_o = 10'h000;
    sel_o = 4'h0;
    dat_o = 32'h0;
  end
  task xfer(input logic w, input logic [9:0] a, input logic [3:0] s,
            input logic [31:0] d, output logic [31:0] q);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= w;
    adr_o <= a;
    sel_o <= s;
    dat_o <= d;
    do @(posedge clk_i); while (ack_i !== 1'b1);
    q = dat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    adr_o <= ~a;
    dat_o <= ~d;
    @(posedge clk_i);
  endtask
endmodule // wb_master_model
`default_nettype wire

// ### verification/general_purpose_timer_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module general_purpose_timer_tb_top;
  logic clk_i, reset_i, fclk_en_i, pin_i;
  wire logic cyc, stb, we, ack, pin_o, pin_oe_o, trig_o, gpo_o, irq_o;
  wire logic [9:0]  adr;
  wire logic [3:0]  sel;
  wire logic [31:0] wdat, rdat;
  logic [31:0] mdl [0:7];
  logic [31:0] msk [0:7];
  logic [31:0] rnd;
  int n_fail, checks_done;
  general_purpose_timer uut (.clk_i(clk_i), .reset_i(reset_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .fclk_en_i(fclk_en_i), .pin_i(pin_i), .pin_o(pin_o),
    .pin_oe_o(pin_oe_o), .trig_o(trig_o), .gpo_o(gpo_o), .irq_o(irq_o));
  wb_master_model mst (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat),
    .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel),
    .dat_o(wdat));
  task report_and_stop;
    if (n_fail == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task cmp(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      n_fail++;
    end
  endtask
  task w(input int i, input logic [3:0] s, input logic [31:0] d);
    logic [31:0] q, nv;
    mst.xfer(1'b1, 10'(i * 4), s, d, q);
    if (i < 8 && i != 4) begin
      nv = (i == 5) ? (mdl[5] & ~d) : d;
      if (s[0] & s[1]) mdl[i][15:0] = nv[15:0];
      if (s[2] & s[3]) mdl[i][31:16] = nv[31:16];
      mdl[i] = mdl[i] & msk[i];
    end
  endtask
  task chk(input int i);
    logic [31:0] q;
    mst.xfer(1'b0, 10'(i * 4), 4'hf, 32'h0, q);
    cmp(q, (i < 8) ? mdl[i] : 32'h0);
  endtask
  task pulse(input int k);
    repeat (k) begin
      fclk_en_i <= 1'b1;
      @(posedge clk_i);
      fclk_en_i <= 1'b0;
      @(posedge clk_i);
    end
  endtask
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  // watchdog, about ten times the expected run
  initial begin
    #600000;
    n_fail++;
    report_and_stop;
  end
  initial begin
    reset_i = 1'b1;
    fclk_en_i = 1'b0;
    pin_i = 1'b0;
    n_fail = 0;
    checks_done = 0;
    mdl = '{32'h0, 32'h0, 32'h0, 32'hffffffff, 32'h0, 32'h0, 32'h0, 32'h0};
    msk = '{32'hfff, '1, '1, '1, '1, 32'hf, 32'hf, 32'h1};
    rnd = $urandom(32'he50d);
    repeat (10) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    for (int i = 0; i < 9; i++) chk(i == 8 ? 255 : i);
    rnd = $urandom;
    w(3, 4'hf, rnd);
    w(3, 4'h3, ~rnd);
    w(3, 4'h1, 32'h0);
    w(3, 4'hc, 32'h5a5a0000);
    chk(3);
    w(255, 4'hf, rnd);
    chk(255);
    w(1, 4'hf, $urandom & 32'h7fffffff);
    // pass nine uses field code 15, which divides as code 8
    for (int n = 0; n < 10; n++) begin
      w(0, 4'hf, 32'h0);
      w(0, 4'hf, 32'(((n == 9 ? 15 : n) << 4) | 1));
      pulse((2 << (n == 9 ? 8 : n)) - 1);
      mdl[1]++;
      chk(1);
    end
    w(0, 4'hf, 32'h0);
    w(0, 4'hf, 32'h1);
    pulse(1);
    w(1, 4'hf, $urandom & 32'h7fffffff);
    pulse(1);
    mdl[1]++;
    chk(1);
    w(0, 4'hf, 32'h0);
    pulse(2);
    chk(1);
    w(6, 4'hf, 32'hf);
    w(2, 4'hf, $urandom);
    w(1, 4'hf, 32'hffffffff);
    w(0, 4'hf, 32'h3);
    pulse(1);
    mdl[1] = mdl[2];
    mdl[5] = 32'h1;
    chk(1);
    chk(5);
    cmp({31'h0, irq_o}, 32'h1);
    w(5, 4'hf, 32'h1);
    cmp({31'h0, irq_o}, 32'h0);
    w(1, 4'hf, 32'hffffffff);
    w(0, 4'hf, 32'h1);
    pulse(1);
    mdl[1] = 32'h0;
    mdl[0] = 32'h0;
    mdl[5] = 32'h1;
    chk(1);
    chk(0);
    w(5, 4'hf, 32'h1);
    w(1, 4'hf, 32'h10);
    w(3, 4'hf, 32'h12);
    w(0, 4'hf, 32'h205);
    pulse(2);
    mdl[1] = 32'h12;
    mdl[5] = 32'h2;
    chk(1);
    chk(5);
    cmp({30'h0, trig_o, pin_o}, 32'h3);
    w(5, 4'hf, 32'h2);
    w(0, 4'hf, 32'h9);
    w(1, 4'hf, $urandom);
    pin_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    mdl[4] = mdl[1];
    mdl[5] = 32'h4;
    chk(4);
    chk(5);
    w(5, 4'hf, 32'h4);
    w(0, 4'hf, 32'h109);
    w(1, 4'hf, $urandom);
    pin_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    mdl[4] = mdl[1];
    mdl[5] = 32'h4;
    chk(4);
    chk(5);
    w(5, 4'hf, 32'h4);
    w(0, 4'hf, 32'h0);
    w(7, 4'hf, 32'h1);
    pulse(33);
    mdl[5] = 32'h8;
    chk(5);
    cmp({31'h0, irq_o}, 32'h1);
    w(6, 4'hf, 32'h0);
    cmp({31'h0, irq_o}, 32'h0);
    w(0, 4'hf, 32'hc00);
    cmp({31'h0, gpo_o}, 32'h1);
    cmp({31'h0, pin_oe_o}, 32'h1);
    chk(0);
    report_and_stop;
  end
endmodule // general_purpose_timer_tb_top
`default_nettype wire
